// *** logic/pcsd_decoder.sv ***
// programmable sum-of-products chip-select decoder with address latch
`include "pcsd_regs.svh"
//
// Contract
// - four, two, one terms per select group
// - term matches high, low or dont-care
// - upper extended inputs take any signal
// - read and write strobes from rw, enable
// - low address captured on address strobe
// - latched address on first port pins
// - standard inputs are address 11 to 15
// - third port pins as inputs 16-18
// - shared pin: address 19 or power-down
// - extended inputs may be dont-care
// - muxed 8-bit bus, rw plus enable
// - reset and latch polarity programmable
// - inputs 16-19 optionally latched on strobe
// - selects 0-7 drive like-numbered second port pins, 8-10 third port pins 0-2
// - pin is select or other, never both
// - select pins push-pull or open-drain
module pcsd_decoder (
    // clock and reset
    input  wire  logic                           i_clk,
    input  wire  logic                           i_srst,
    // host bus
    input  wire  logic [7:0]                     i_ad,
    input  wire  logic                           i_host_address_strobe,
    input  wire  logic                           i_rw,
    input  wire  logic                           i_e,
    input  wire  logic [`PCSD_NSTD-1:0]          i_addr_hi,
    input  wire  logic                           i_rst_pin,
    // pin inputs
    input  wire  logic [`PCSD_NPC-1:0]           i_third_port_in,
    input  wire  logic                           i_shared_in,
    // configuration
    input  wire  pcsd_pkg::pcsd_bus_cfg_t        i_bus_cfg,
    input  wire  pcsd_pkg::pcsd_term_t [`PCSD_NTERM-1:0] i_terms,
    input  wire  pcsd_pkg::pcsd_cspin_t [`PCSD_NCS-1:0]  i_cs_pin,
    input  wire  pcsd_pkg::pcsd_pcmode_t [`PCSD_NPC-1:0] i_pc_mode,
    input  wire  logic [`PCSD_NPA-1:0]           i_pa_addr_sel,
    // general io drive
    input  wire  logic [`PCSD_NPA-1:0]           i_pa_gpio_out,
    input  wire  logic [`PCSD_NPA-1:0]           i_pa_gpio_oe,
    input  wire  logic [`PCSD_NPB-1:0]           i_pb_gpio_out,
    input  wire  logic [`PCSD_NPB-1:0]           i_pb_gpio_oe,
    input  wire  logic [`PCSD_NPC-1:0]           i_pc_gpio_out,
    input  wire  logic [`PCSD_NPC-1:0]           i_pc_gpio_oe,
    // pins
    output logic       [`PCSD_NPA-1:0]           o_first_port_out,
    output logic       [`PCSD_NPA-1:0]           o_first_port_oe,
    output logic       [`PCSD_NPB-1:0]           o_second_port_out,
    output logic       [`PCSD_NPB-1:0]           o_second_port_oe,
    output logic       [`PCSD_NPC-1:0]           o_third_port_out,
    output logic       [`PCSD_NPC-1:0]           o_third_port_oe,
    // status
    output logic       [`PCSD_NCS-1:0]           o_select_status,
    output logic                                 o_power_down
);
    import pcsd_pkg::*;

    // ==========================================================
    // reset and strobes
    logic                   rst;
    logic                   strobe_act;
    logic                   rd_s;
    logic                   wr_s;
    logic                   pd;

    assign rst        = i_srst | (i_rst_pin ^ i_bus_cfg.rst_low);
    assign strobe_act = ~(i_host_address_strobe ^ i_bus_cfg.ale_high);

    always_comb begin
        if (i_bus_cfg.rw_e_mode) begin
            // read rw high, write rw low
            rd_s = i_rw & i_e;
            wr_s = ~i_rw & i_e;
        end else begin
            // active-low read and write on the same pins
            rd_s = ~i_rw;
            wr_s = ~i_e;
        end
    end

    assign pd = ~i_bus_cfg.shared_is_addr & ~i_shared_in;

    // ==========================================================
    // address latch
    logic [7:0]             addr_lo_q;
    logic [7:0]             addr_lo_d;
    logic [`PCSD_NEXT-1:0]  ext_q;
    logic [`PCSD_NEXT-1:0]  ext_d;
    logic [`PCSD_NEXT-1:0]  ext_live;
    logic [`PCSD_NEXT-1:0]  ext_addr_in;

    // third port pins feed inputs 16-18
    always_comb begin
        for (int k = 0; k < `PCSD_NPC; k++) begin
            ext_live[k] = (i_pc_mode[k] == PCSD_PC_ADDR) & i_third_port_in[k];
        end
        ext_live[`PCSD_NEXT-1] = i_bus_cfg.shared_is_addr & i_shared_in;
    end

    always_comb begin
        addr_lo_d = addr_lo_q;
        ext_d     = ext_q;
        // non-muxed bus carries a steady address, so follow it
        // capture on address strobe
        if (strobe_act | ~i_bus_cfg.muxed) begin
            addr_lo_d = i_ad;
        end
        // hold extended inputs for the cycle
        if (strobe_act) begin
            ext_d = ext_live;
        end
    end

    always_ff @(posedge i_clk) begin
        if (rst) begin
            addr_lo_q <= `PCSD_ADDR_RST;
            ext_q     <= `PCSD_EXT_RST;
        end else begin
            addr_lo_q <= addr_lo_d;
            ext_q     <= ext_d;
        end
    end

    // transparent while the strobe is active, held after it
    assign ext_addr_in = (i_bus_cfg.latch_ext & ~strobe_act) ? ext_q : ext_live;

    // ==========================================================
    // product terms
    logic [`PCSD_NIN-1:0]   dec_in;
    logic [`PCSD_NTERM-1:0] hit;
    logic [`PCSD_NCS-1:0]   cs_raw;

    // address 11-15 from the host, 16-19 extended
    // extended inputs need not be address
    assign dec_in = {ext_addr_in, i_addr_hi, strobe_act, rd_s, wr_s};

    generate
        for (genvar t = 0; t < `PCSD_NTERM; t++) begin : g_term
            pcsd_term u_term (
                .i_term (i_terms[t]),
                .i_in   (dec_in),
                .o_hit  (hit[t])
            );
        end
        // four, two and one terms per group
        for (genvar c = 0; c < `PCSD_NCS; c++) begin : g_cs
            if (c < `PCSD_G2_CS) begin : g_four
                assign cs_raw[c] = |hit[c*`PCSD_G1_N +: `PCSD_G1_N];
            end else if (c < `PCSD_G3_CS) begin : g_two
                assign cs_raw[c] =
                    |hit[`PCSD_G2_BASE + (c-`PCSD_G2_CS)*`PCSD_G2_N +: `PCSD_G2_N];
            end else begin : g_one
                assign cs_raw[c] = hit[`PCSD_G3_BASE + c - `PCSD_G3_CS];
            end
        end
    endgenerate

    // ==========================================================
    // pin drive
    // open-drain pins only pull low, letting several selects wire-OR
    function automatic logic [1:0] cs_drive(input pcsd_cspin_t p, input logic act);
        logic lvl;
        lvl = act ^ p.active_low;
        if (p.open_drain) begin
            cs_drive = {1'b0, ~lvl};
        end else begin
            cs_drive = {lvl, 1'b1};
        end
    endfunction

    logic [`PCSD_NPA-1:0]   pa_out_d;
    logic [`PCSD_NPA-1:0]   pa_oe_d;
    logic [`PCSD_NPB-1:0]   pb_out_d;
    logic [`PCSD_NPB-1:0]   pb_oe_d;
    logic [`PCSD_NPC-1:0]   pc_out_d;
    logic [`PCSD_NPC-1:0]   pc_oe_d;
    logic [`PCSD_NCS-1:0]   cs_d;
    logic [1:0]             drv;

    always_comb begin
        drv  = 2'h0;
        // power-down forces every select inactive
        cs_d = pd ? '0 : cs_raw;
        for (int k = 0; k < `PCSD_NPA; k++) begin
            pa_out_d[k] = i_pa_addr_sel[k] ? addr_lo_q[k] : i_pa_gpio_out[k];
            pa_oe_d[k]  = i_pa_addr_sel[k] | i_pa_gpio_oe[k];
        end
        // select n on second port pin n
        for (int k = 0; k < `PCSD_NPB; k++) begin
            drv = cs_drive(i_cs_pin[k], cs_d[k]);
            pb_out_d[k] = i_cs_pin[k].use_cs ? drv[1] : i_pb_gpio_out[k];
            pb_oe_d[k]  = i_cs_pin[k].use_cs ? drv[0] : i_pb_gpio_oe[k];
        end
        for (int k = 0; k < `PCSD_NPC; k++) begin
            drv = cs_drive(i_cs_pin[k+`PCSD_G3_CS], cs_d[k+`PCSD_G3_CS]);
            // third port select, input or io
            case (i_pc_mode[k])
                PCSD_PC_CS: begin
                    pc_out_d[k] = drv[1];
                    pc_oe_d[k]  = drv[0];
                end
                PCSD_PC_ADDR: begin
                    pc_out_d[k] = 1'b0;
                    pc_oe_d[k]  = 1'b0;
                end
                PCSD_PC_GPIO: begin
                    pc_out_d[k] = i_pc_gpio_out[k];
                    pc_oe_d[k]  = i_pc_gpio_oe[k];
                end
                default: begin
                    pc_out_d[k] = 1'b0;
                    pc_oe_d[k]  = 1'b0;
                end
            endcase
        end
    end

    // registered pins add one clock of delay to every select
    always_ff @(posedge i_clk) begin
        if (rst) begin
            o_first_port_out  <= '0;
            o_first_port_oe   <= '0;
            o_second_port_out <= '0;
            o_second_port_oe  <= '0;
            o_third_port_out  <= '0;
            o_third_port_oe   <= '0;
            o_select_status   <= '0;
            o_power_down      <= 1'b0;
        end else begin
            o_first_port_out  <= pa_out_d;
            o_first_port_oe   <= pa_oe_d;
            o_second_port_out <= pb_out_d;
            o_second_port_oe  <= pb_oe_d;
            o_third_port_out  <= pc_out_d;
            o_third_port_oe   <= pc_oe_d;
            o_select_status   <= cs_d;
            o_power_down      <= pd;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (rst);

    addr_latch_a: assert property (
        strobe_act && i_bus_cfg.muxed |=> addr_lo_q == $past(i_ad))
        else $error("low address not captured on strobe");
    addr_hold_a: assert property (
        !strobe_act && i_bus_cfg.muxed ##1 !strobe_act && i_bus_cfg.muxed
        |-> $stable(addr_lo_q))
        else $error("low address moved outside strobe");
    ext_hold_a: assert property (
        i_bus_cfg.latch_ext && strobe_act ##1 i_bus_cfg.latch_ext && !strobe_act
        |-> ext_addr_in == $past(ext_live))
        else $error("extended inputs not held after strobe");
    addr_out_a: assert property (
        !$past(rst) |-> o_first_port_out ==
        (($past(i_pa_addr_sel) & $past(addr_lo_q)) |
         (~$past(i_pa_addr_sel) & $past(i_pa_gpio_out))))
        else $error("first port address drive wrong");
    sel_sum_a: assert property (
        !pd && !rst ##1 1'b1 |-> o_select_status[0] ==
        $past(|hit[`PCSD_G1_N-1:0]) && o_select_status[`PCSD_G3_CS] ==
        $past(hit[`PCSD_G3_BASE]))
        else $error("select not the OR of its terms");
    // a blank term beside missing terms must leave the select low
    blank_term_a: assert property (
        !i_terms[3].en && !(|hit[2:0]) && !pd |=> !o_select_status[0])
        else $error("blank term asserted");
    pd_quiet_a: assert property (
        pd ##1 !rst |-> o_select_status == '0 && o_power_down)
        else $error("select active in power-down");
    rd_strobe_a: assert property (
        i_bus_cfg.rw_e_mode && i_rw && i_e && i_terms[18].en
        && i_terms[18].care == 12'(1 << `PCSD_IN_RD) && i_terms[18].val[`PCSD_IN_RD] && !pd
        |=> o_select_status[5])
        else $error("read strobe missed");
    wr_strobe_a: assert property (
        i_bus_cfg.rw_e_mode && !i_rw && i_e && i_terms[20].en
        && i_terms[20].care == 12'(1 << `PCSD_IN_WR) && i_terms[20].val[`PCSD_IN_WR] && !pd
        |=> o_select_status[6])
        else $error("write strobe missed");
    // separate-strobe mode: the rw pin itself is the active-low read
    sep_strobe_a: assert property (
        !i_bus_cfg.rw_e_mode && !i_rw && i_terms[18].en
        && i_terms[18].care == 12'(1 << `PCSD_IN_RD) && i_terms[18].val[`PCSD_IN_RD] && !pd
        |=> o_select_status[5])
        else $error("separate read strobe missed");
    // open-drain select only ever pulls low, never drives high
    od_drive_a: assert property (
        i_pc_mode[2] == PCSD_PC_CS && i_cs_pin[10].open_drain ##1 !rst
        |-> !o_third_port_out[2])
        else $error("open-drain pin driven high");
    pc_input_a: assert property (
        i_pc_mode[0] == PCSD_PC_ADDR ##1 !rst |-> !o_third_port_oe[0])
        else $error("address input pin driven");
endmodule

// *** logic/pcsd_pkg.sv ***
// types of the chip-select decoder
`include "pcsd_regs.svh"
package pcsd_pkg;
    typedef struct packed {
        logic                 en;
        logic [`PCSD_NIN-1:0] care;
        logic [`PCSD_NIN-1:0] val;
    } pcsd_term_t;
    typedef struct packed {
        logic use_cs;
        logic open_drain;
        logic active_low;
    } pcsd_cspin_t;
    typedef struct packed {
        logic muxed;
        logic rw_e_mode;
        logic bus_8bit;
        logic rst_low;
        logic ale_high;
        logic latch_ext;
        logic shared_is_addr;
    } pcsd_bus_cfg_t;
    typedef enum logic [1:0] {
        PCSD_PC_GPIO,
        PCSD_PC_CS,
        PCSD_PC_ADDR
    } pcsd_pcmode_t;
endpackage

// *** logic/pcsd_regs.svh ***
// constants of the chip-select decoder: counts, input positions, term layout
`ifndef PCSD_REGS_SVH
`define PCSD_REGS_SVH
// decoder inputs per product term
`define PCSD_NIN      12
// decoder input positions
`define PCSD_IN_WR    0
`define PCSD_IN_RD    1
`define PCSD_IN_ALE   2
`define PCSD_IN_ADDR  3
`define PCSD_IN_EXT   8
`define PCSD_NSTD     5
`define PCSD_NEXT     4
// term pool and its split over the selects
`define PCSD_NTERM    27
`define PCSD_NCS      11
`define PCSD_G2_CS    4
`define PCSD_G3_CS    8
`define PCSD_G1_N     4
`define PCSD_G2_N     2
`define PCSD_G2_BASE  16
`define PCSD_G3_BASE  24
// pin counts
`define PCSD_NPA      8
`define PCSD_NPB      8
`define PCSD_NPC      3
`define PCSD_NCFG_PC  3
// reset values
`define PCSD_ADDR_RST 8'h00
`define PCSD_EXT_RST  4'h0
`endif

// *** logic/pcsd_term.sv ***
// one product term: every cared input must equal its programmed level
`include "pcsd_regs.svh"
module pcsd_term (
    // programming
    input  wire pcsd_pkg::pcsd_term_t  i_term,
    // decoder inputs
    input  wire logic [`PCSD_NIN-1:0]  i_in,
    // match
    output logic                       o_hit
);
    import pcsd_pkg::*;
    assign o_hit = i_term.en & ~|((i_in ^ i_term.val) & i_term.care);
endmodule

// *** tb/pcsd_host_model.sv ***
// host bus model: multiplexed low address and data, address strobe, rw and enable
module pcsd_host_model (
    // clock
    input  wire logic       i_clk,
    // host bus
    output logic [7:0]      o_ad,
    output logic            o_as,
    output logic            o_rw,
    output logic            o_e,
    output logic [4:0]      o_addr_hi
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        o_ad = 8'h00;
        o_as = 1'b0;
        o_rw = 1'b1;
        o_e = 1'b0;
        o_addr_hi = 5'h00;
    end
    // ==========================================
    // bus cycle
    // low address on the shared bus, strobe pulse
    // rw held for the whole cycle
    task automatic cycle(input logic [15:0] a, input logic rd);
        @(posedge i_clk);
        o_as <= 1'b1;
        o_ad <= a[7:0];
        o_addr_hi <= a[15:11];
        o_rw <= rd;
        @(posedge i_clk);
        o_as <= 1'b0;
        // address gone: show its inverse, not a stale copy
        o_ad <= ~a[7:0];
        o_e <= 1'b1;
        repeat (2) @(posedge i_clk);
        o_e <= 1'b0;
    endtask
endmodule

// *** tb/pla_chip_select_decoder_test.sv ***
// self-checking bench of the chip-select decoder
`include "pcsd_regs.svh"
module pla_chip_select_decoder_test;
    import pcsd_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, srst, as_s, rw, e, rst_pin, shared;
    logic [7:0] ad, gp_out, gp_oe, pa_sel, fp_out, fp_oe, sp_out, sp_oe;
    logic [4:0] hi;
    logic [2:0] pc_in, tp_out, tp_oe;
    logic [10:0] status;
    logic pd;
    pcsd_bus_cfg_t cfg;
    pcsd_term_t [`PCSD_NTERM-1:0] terms;
    pcsd_cspin_t [`PCSD_NCS-1:0] pins;
    pcsd_pcmode_t [`PCSD_NPC-1:0] pcm;
    int errors, samples_checked;
    always #12.5 clk = ~clk;
    pcsd_host_model u_host (.i_clk(clk), .o_ad(ad), .o_as(as_s), .o_rw(rw), .o_e(e),
        .o_addr_hi(hi));
    pcsd_decoder u_dut (.i_clk(clk), .i_srst(srst), .i_ad(ad), .i_host_address_strobe(as_s),
        .i_rw(rw), .i_e(e), .i_addr_hi(hi), .i_rst_pin(rst_pin), .i_third_port_in(pc_in),
        .i_shared_in(shared), .i_bus_cfg(cfg), .i_terms(terms), .i_cs_pin(pins),
        .i_pc_mode(pcm), .i_pa_addr_sel(pa_sel), .i_pa_gpio_out(gp_out), .i_pa_gpio_oe(gp_oe),
        .i_pb_gpio_out(gp_out), .i_pb_gpio_oe(gp_oe), .i_pc_gpio_out(3'h0),
        .i_pc_gpio_oe(3'h0), .o_first_port_out(fp_out), .o_first_port_oe(fp_oe),
        .o_second_port_out(sp_out), .o_second_port_oe(sp_oe), .o_third_port_out(tp_out),
        .o_third_port_oe(tp_oe), .o_select_status(status), .o_power_down(pd));
    // ==========================================
    // checking
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // x holds extended inputs 19..16 as the decoder should see them
    function automatic logic [10:0] exp_sel(input logic [15:0] a, input logic rd,
                                            input logic [3:0] x);
        logic [10:0] s;
        s = 11'h000;
        s[0] = (a[15] & a[14] & ~a[13] & ~x[1] & rd) | (~a[15] & a[14] & a[12] & ~rd) | x[0];
        s[3] = rd;
        s[4] = rd;
        s[5] = rd;
        s[6] = ~rd;
        s[10] = rd & x[3];
        return s;
    endfunction
    task automatic bus_check(input logic [15:0] a, input logic rd, input logic [3:0] x,
                             input logic down);
        logic [10:0] s;
        s = down ? 11'h000 : exp_sel(a, rd, x);
        u_host.cycle(a, rd);
        #1;
        chk(16'(status), 16'(s));
        chk(16'(sp_out), 16'({1'b1, ~s[6:0]}));
        chk(16'(sp_oe), 16'h00FF);
        chk(16'(fp_out), 16'({5'h15, a[2:0]}));
        chk(16'(fp_oe), 16'h00F7);
        chk(16'(tp_oe), 16'({s[10], 2'b00}));
        chk(16'(tp_out & tp_oe), 16'h0000);
        chk(16'(pd), 16'(down));
    endtask
    // ==========================================
    // scenarios
    task automatic t_strobes();
        bus_check(16'h0000, 1'b1, 4'h0, 1'b0);
        bus_check(16'h0000, 1'b0, 4'h0, 1'b0);
    endtask
    task automatic t_terms();
        logic [15:0] ta [6] = '{16'hC005, 16'hE006, 16'h5003, 16'h5001, 16'hC007, 16'h0004};
        logic tr [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
        logic [1:0] tx [6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h1};
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            pc_in <= {1'b0, tx[i]};
            bus_check(ta[i], tr[i], {2'b00, tx[i]}, 1'b0);
        end
    endtask
    // extended input drops right after the strobe
    task automatic t_latch(input logic lat);
        @(posedge clk);
        cfg.latch_ext <= lat;
        pc_in <= 3'b001;
        fork
            bus_check(16'h0000, 1'b1, {3'b000, lat}, 1'b0);
            begin
                repeat (2) @(posedge clk);
                pc_in <= 3'b000;
            end
        join
    endtask
    task automatic t_power();
        @(posedge clk);
        shared <= 1'b1;
        bus_check(16'h0000, 1'b1, 4'h8, 1'b0);
        @(posedge clk);
        shared <= 1'b0;
        cfg.shared_is_addr <= 1'b0;
        bus_check(16'h0000, 1'b1, 4'h0, 1'b1);
        @(posedge clk);
        shared <= 1'b1;
        bus_check(16'h0000, 1'b1, 4'h0, 1'b0);
    endtask
    // separate strobes and a non-muxed bus in one cycle
    task automatic t_modes();
        @(posedge clk);
        cfg.muxed <= 1'b0;
        cfg.rw_e_mode <= 1'b0;
        u_host.cycle(16'h0005, 1'b0);
        #1;
        chk(16'(status), 16'h0038);
        chk(16'(fp_out), 16'h00AA);
        @(posedge clk);
        cfg.muxed <= 1'b1;
        cfg.rw_e_mode <= 1'b1;
    endtask
    task automatic t_rst_pin();
        @(posedge clk);
        rst_pin <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk(16'(sp_oe), 16'h0000);
        @(posedge clk);
        cfg.rst_low <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk(16'(sp_oe), 16'h00FF);
    endtask
    // ==========================================
    // main sequence
    initial begin
        clk = 1'b0;
        srst <= 1'b1;
        rst_pin <= 1'b1;
        shared <= 1'b0;
        pc_in <= 3'b000;
        gp_out <= 8'hA8;
        gp_oe <= 8'hF0;
        pa_sel <= 8'h07;
        cfg <= 7'h7F;
        pcm[0] <= PCSD_PC_ADDR;
        pcm[1] <= PCSD_PC_ADDR;
        pcm[2] <= PCSD_PC_CS;
        for (int i = 0; i < `PCSD_NTERM; i++) terms[i] <= '0;
        for (int i = 0; i < `PCSD_NCS; i++) pins[i] <= 3'b101;
        pins[7] <= 3'b001;
        pins[10] <= 3'b111;
        terms[0] <= {1'b1, 12'h2E2, 12'h0C2};
        terms[1] <= {1'b1, 12'h0D1, 12'h051};
        terms[2] <= {1'b1, 12'h100, 12'h100};
        terms[15] <= {1'b1, 12'h002, 12'h002};
        terms[17] <= {1'b1, 12'h002, 12'h002};
        terms[18] <= {1'b1, 12'h002, 12'h002};
        terms[20] <= {1'b1, 12'h001, 12'h001};
        terms[26] <= {1'b1, 12'h802, 12'h802};
        repeat (5) @(posedge clk);
        #1;
        chk(16'(fp_oe), 16'h0000);
        @(posedge clk);
        srst <= 1'b0;
        t_strobes();
        t_terms();
        t_latch(1'b1);
        t_latch(1'b0);
        t_power();
        t_modes();
        t_rst_pin();
        give_verdict();
    end
    // cuts a hang short, far beyond the 81 cycles the run needs
    initial begin
        repeat (3000) @(posedge clk);
        errors++;
        give_verdict();
    end
endmodule
